// [rtl/slia_pkg.sv]
// Constants, types and register map of the serial link interrupt/map block
// Summary of operation
// - The pending/set register reads back pending interrupts while local select is clear.
// - Pending bits clear once their interrupt packet has gone out on the link.
// - Writing a one with local select clear sends an interrupt packet.
// - Writing a one with local select set raises the port interrupt output.
// - Zero bits written to pending/set leave pending bits unchanged.
// - Pointer, transmit map and region size use bits 31-2; bits 1-0 read zero.
// - Outbound address bits 25:0 minus the transmit map give the packet address.
// - An inbound address below region 1 size gets region 1 offset added.
// - The region 1 size register defines the one inbound region that the block remaps.
// - Pending/set, pointer, transmit map and region 1 size reset to zero.
// - Region 1 offset uses bits 31-2, bits 1-0 read zero, reset zero.
package slia_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_PEND_SET = 8'h14;
  localparam logic [7:0] OFS_INT_PTR = 8'h18;
  localparam logic [7:0] OFS_TX_MAP = 8'h1C;
  localparam logic [7:0] OFS_RX1_SIZE = 8'h20;
  localparam logic [7:0] OFS_RX1_OFFSET = 8'h24;
  localparam logic [7:0] OFS_EVT_STATUS = 8'h40;
  localparam logic [7:0] OFS_EVT_CLEAR = 8'h44;
  localparam logic [7:0] OFS_EVT_ENABLE = 8'h48;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_LOCAL_BIT = 0;
  localparam int CTRL_INTERRUPT_TO_CONFIG_SELECT_BIT = 1;
  localparam logic [31:0] WORD_MASK = 32'hFFFF_FFFC;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam int TX_ADDR_W = 26;
  localparam int EVT_PKT_SENT = 0;
  localparam int EVT_LOCAL_INT = 1;
  localparam int EVT_W = 2;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic hsel;
    logic hready;
  } slia_ahb_req_s;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } slia_ahb_rsp_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SEND
  } slia_tx_state_e;

endpackage : slia_pkg

// [rtl/slia_regs.sv]
// Serial link interrupt pending/set, pointer and address map registers
module slia_regs
  import slia_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire slia_ahb_req_s i_ahb,
  output slia_ahb_rsp_s o_ahb,
  output logic o_pkt_valid,
  output logic [31:0] o_pkt_bits,
  input wire logic i_pkt_ready,
  output logic o_port_interrupt_out,
  output logic o_irq,
  input wire logic [31:0] i_tx_bus_addr,
  output logic [31:0] o_tx_pkt_addr,
  input wire logic [31:0] i_rx_pkt_addr,
  output logic [31:0] o_rx_local_addr,
  output logic o_rx_region1_hit,
  output logic o_interrupt_to_config_select,
  output logic [31:0] o_interrupt_pointer
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] word_field(input logic [31:0] d);
    word_field = d & WORD_MASK;
  endfunction : word_field

  // ----------------------------------------------------------------
  // Bus address phase capture
  // ----------------------------------------------------------------
  logic wr_pend_r, wr_pend_nxt;
  logic rd_pend_r, rd_pend_nxt;
  logic [7:0] addr_r, addr_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic take;

  assign take = i_ahb.hsel && i_ahb.hready && i_ahb.htrans[1];

  always_comb
  begin
    wr_pend_nxt = take && i_ahb.hwrite;
    rd_pend_nxt = take && !i_ahb.hwrite;
    addr_nxt = take ? i_ahb.haddr[7:0] : addr_r;
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [1:0] ctrl_r, ctrl_nxt;
  logic [31:0] pend_r, pend_nxt;
  logic [31:0] ptr_r, ptr_nxt;
  logic [31:0] txmap_r, txmap_nxt;
  logic [31:0] rx1s_r, rx1s_nxt;
  logic [31:0] rx1o_r, rx1o_nxt;
  logic [EVT_W-1:0] evst_r, evst_nxt;
  logic [EVT_W-1:0] even_r, even_nxt;
  logic [31:0] pkt_r, pkt_nxt;
  logic lint_r, lint_nxt;
  slia_tx_state_e st_r, st_nxt;
  logic [31:0] wd;
  logic wr_pend_set, pkt_done;
  logic [EVT_W-1:0] ev_set, ev_clr;

  assign wd = i_ahb.hwdata;
  assign wr_pend_set = wr_pend_r && (addr_r == OFS_PEND_SET);
  assign pkt_done = (st_r == ST_SEND) && i_pkt_ready;

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    ptr_nxt = ptr_r;
    txmap_nxt = txmap_r;
    rx1s_nxt = rx1s_r;
    rx1o_nxt = rx1o_r;
    even_nxt = even_r;
    pend_nxt = pend_r;
    pkt_nxt = pkt_r;
    lint_nxt = lint_r;
    st_nxt = st_r;
    ev_clr = '0;
    ev_set = '0;
    if (wr_pend_r)
    begin
      case (addr_r)
        OFS_CONTROL: ctrl_nxt = wd[1:0];
        OFS_INT_PTR: ptr_nxt = word_field(wd);
        OFS_TX_MAP: txmap_nxt = word_field(wd);
        OFS_RX1_SIZE: rx1s_nxt = word_field(wd);
        OFS_RX1_OFFSET: rx1o_nxt = word_field(wd);
        OFS_EVT_CLEAR: ev_clr = wd[EVT_W-1:0];
        OFS_EVT_ENABLE: even_nxt = wd[EVT_W-1:0];
        default: ;
      endcase
    end
    // Packet launch: a packet in flight completes before the next starts
    case (st_r)
      ST_IDLE:
      begin
        if (|pend_r && !ctrl_r[CTRL_LOCAL_BIT])
        begin
          pkt_nxt = pend_r;
          st_nxt = ST_SEND;
        end
      end
      ST_SEND:
      begin
        if (i_pkt_ready)
        begin
          pend_nxt = pend_nxt & ~pkt_r;
          ev_set[EVT_PKT_SENT] = 1'b1;
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
    if (wr_pend_set)
    begin
      pend_nxt = pend_nxt | wd;
      if (ctrl_r[CTRL_LOCAL_BIT] && |wd)
      begin
        lint_nxt = 1'b1;
        ev_set[EVT_LOCAL_INT] = 1'b1;
      end
    end
    // Local interrupt holds while local select is set and any pending bit stays set
    if (!ctrl_r[CTRL_LOCAL_BIT] || ~|pend_nxt)
    begin
      lint_nxt = 1'b0;
    end
    // Set wins over a simultaneous clear
    evst_nxt = (evst_r & ~ev_clr) | ev_set;
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 8'h00;
      rdata_r <= RESET_WORD;
      ctrl_r <= 2'h0;
      pend_r <= RESET_WORD;
      ptr_r <= RESET_WORD;
      txmap_r <= RESET_WORD;
      rx1s_r <= RESET_WORD;
      rx1o_r <= RESET_WORD;
      evst_r <= '0;
      even_r <= '0;
      pkt_r <= RESET_WORD;
      lint_r <= 1'b0;
      st_r <= ST_IDLE;
    end
    else
    begin
      wr_pend_r <= wr_pend_nxt;
      rd_pend_r <= rd_pend_nxt;
      addr_r <= addr_nxt;
      rdata_r <= rdata_nxt;
      ctrl_r <= ctrl_nxt;
      pend_r <= pend_nxt;
      ptr_r <= ptr_nxt;
      txmap_r <= txmap_nxt;
      rx1s_r <= rx1s_nxt;
      rx1o_r <= rx1o_nxt;
      evst_r <= evst_nxt;
      even_r <= even_nxt;
      pkt_r <= pkt_nxt;
      lint_r <= lint_nxt;
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read mux, sampled in the address phase for a registered answer
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_nxt = RESET_WORD;
    if (take && !i_ahb.hwrite)
    begin
      case (i_ahb.haddr[7:0])
        OFS_CONTROL: rdata_nxt = {30'h0, ctrl_r};
        OFS_PEND_SET: rdata_nxt = ctrl_r[CTRL_LOCAL_BIT] ? RESET_WORD
                                                         : pend_r;
        OFS_INT_PTR: rdata_nxt = ptr_r;
        OFS_TX_MAP: rdata_nxt = txmap_r;
        OFS_RX1_SIZE: rdata_nxt = rx1s_r;
        OFS_RX1_OFFSET: rdata_nxt = rx1o_r;
        OFS_EVT_STATUS: rdata_nxt = {30'h0, evst_r};
        OFS_EVT_ENABLE: rdata_nxt = {30'h0, even_r};
        default: rdata_nxt = RESET_WORD;
      endcase
    end
  end

  // Zero wait state slave; a read that collides with a write to the
  // same register returns the old value
  assign o_ahb.hrdata = rdata_r;
  assign o_ahb.hreadyout = 1'b1;
  assign o_ahb.hresp = 1'b0;

  // ----------------------------------------------------------------
  // Address translation
  // ----------------------------------------------------------------
  // outbound rebase
  assign o_tx_pkt_addr = {6'h00, i_tx_bus_addr[TX_ADDR_W-1:0]
                                 - txmap_r[TX_ADDR_W-1:0]};
  assign o_rx_region1_hit = i_rx_pkt_addr < rx1s_r;
  assign o_rx_local_addr = o_rx_region1_hit ? i_rx_pkt_addr + rx1o_r
                                            : i_rx_pkt_addr;

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_pkt_valid = (st_r == ST_SEND);
  assign o_pkt_bits = pkt_r;
  assign o_port_interrupt_out = lint_r;
  assign o_irq = |(evst_r & even_r);
  assign o_interrupt_to_config_select = ctrl_r[CTRL_INTERRUPT_TO_CONFIG_SELECT_BIT];
  assign o_interrupt_pointer = ptr_r;

endmodule : slia_regs

// [verif/slia_link_model.sv]
// Link side model that takes interrupt packets a cycle after offer, or stalled
module slia_link_model (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_valid,
  input wire logic i_stall,
  output logic o_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  // Ready comes a cycle late, so a prompt link still costs a cycle
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
    if (!i_arst_n)
      o_ready <= 1'h0;
    else
      o_ready <= i_valid && !i_stall && !o_ready;
endmodule : slia_link_model

// [verif/slia_regs_bench.sv]
// Self-checking bench of the serial link interrupt and map registers
module slia_regs_bench import slia_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, arst_n, stall, ready, hsel, hwrite, rdy;
  logic pkt_valid, port_int, irq, hit, interrupt_to_config_select;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, tx_addr, rx_addr, q;
  logic [31:0] pkt_bits, tx_pkt, rx_local, iptr;
  slia_ahb_req_s req;
  slia_ahb_rsp_s rsp;
  int bad_count, n_tests;
  assign req = '{htrans, hwrite, 3'h2, haddr, hwdata, hsel, rsp.hreadyout};
  slia_regs dut (.i_ref_clk(clk), .i_arst_n(arst_n), .i_ahb(req),
    .o_ahb(rsp), .o_pkt_valid(pkt_valid), .o_pkt_bits(pkt_bits),
    .i_pkt_ready(ready), .o_port_interrupt_out(port_int), .o_irq(irq),
    .i_tx_bus_addr(tx_addr), .o_tx_pkt_addr(tx_pkt),
    .i_rx_pkt_addr(rx_addr), .o_rx_local_addr(rx_local),
    .o_rx_region1_hit(hit), .o_interrupt_to_config_select(interrupt_to_config_select),
    .o_interrupt_pointer(iptr));
  slia_link_model u_link (.i_ref_clk(clk), .i_arst_n(arst_n),
    .i_valid(pkt_valid), .i_stall(stall), .o_ready(ready));
  // ----------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Read data is taken at the closing data phase edge, before it updates
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (!rsp.hreadyout);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (!rsp.hreadyout);
    q = rsp.hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'h0, a, 32'h0);
    chk(q, e);
  endtask : rdc
  task automatic wait_pkt(input logic v);
    repeat (20) if (pkt_valid !== v) @(negedge clk);
    chk(32'(pkt_valid), 32'(v));
  endtask : wait_pkt
  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_regs;
    logic [7:0] ofs [5] = '{OFS_PEND_SET, OFS_INT_PTR, OFS_TX_MAP,
      OFS_RX1_SIZE, OFS_RX1_OFFSET};
    foreach (ofs[i]) rdc(ofs[i], RESET_WORD);
    for (int i = 1; i < 5; i++)
    begin
      wr(ofs[i], 32'hFFFF_FFFF);
      rdc(ofs[i], WORD_MASK);
    end
    wr(8'h30, 32'hFFFF_FFFF);
    rdc(8'h30, 32'h0);
    wr(OFS_INT_PTR, 32'h14);
    rdc(OFS_INT_PTR, 32'h14);
    chk(iptr, 32'h14);
  endtask : t_regs
  task automatic t_map;
    wr(OFS_TX_MAP, 32'h100);
    wr(OFS_RX1_SIZE, 32'h1000);
    wr(OFS_RX1_OFFSET, 32'h8000);
    tx_addr <= 32'h0400_0300;
    rx_addr <= 32'h0FFC;
    @(negedge clk);
    chk(tx_pkt, 32'h200);
    chk(32'(hit), 32'h1);
    chk(rx_local, 32'h8FFC);
    @(posedge clk);
    rx_addr <= 32'h1000;
    @(negedge clk);
    chk(rx_local, 32'h1000);
    chk(32'(hit), 32'h0);
    wr(OFS_TX_MAP, 32'h0);
    rdc(OFS_TX_MAP, 32'h0);
  endtask : t_map
  task automatic t_pkt;
    stall <= 1'h1;
    wr(OFS_PEND_SET, 32'h5);
    wait_pkt(1'h1);
    chk(pkt_bits, 32'h5);
    wr(OFS_PEND_SET, 32'h0);
    rdc(OFS_PEND_SET, 32'h5);
    wr(OFS_EVT_ENABLE, 32'h1);
    stall <= 1'h0;
    wait_pkt(1'h0);
    rdc(OFS_PEND_SET, 32'h0);
    rdc(OFS_EVT_STATUS, 32'h1);
    chk(32'(irq), 32'h1);
    wr(OFS_EVT_ENABLE, 32'h0);
    rdc(OFS_EVT_STATUS, 32'h1);
    chk(32'(irq), 32'h0);
    wr(OFS_EVT_ENABLE, 32'h1);
    wr(OFS_EVT_CLEAR, 32'h1);
    rdc(OFS_EVT_STATUS, 32'h0);
    chk(32'(irq), 32'h0);
  endtask : t_pkt
  task automatic t_local;
    wr(OFS_CONTROL, 32'h3);
    wr(OFS_PEND_SET, 32'h8);
    rdc(OFS_PEND_SET, 32'h0);
    chk(32'(port_int), 32'h1);
    chk(32'(pkt_valid), 32'h0);
    chk(32'(interrupt_to_config_select), 32'h1);
    wr(OFS_CONTROL, 32'h0);
    wait_pkt(1'h1);
    chk(pkt_bits, 32'h8);
    wait_pkt(1'h0);
  endtask : t_local
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    {arst_n, stall, hsel, hwrite, htrans} = '0;
    {haddr, hwdata, tx_addr, rx_addr} = '0;
    repeat (12) @(posedge clk);
    arst_n <= 1'h1;
    t_regs;
    t_map;
    t_pkt;
    t_local;
    stop_test;
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    bad_count++;
    stop_test;
  end
endmodule : slia_regs_bench
bind slia_regs slia_regs_props u_props (.i_ref_clk(i_ref_clk),
  .i_arst_n(i_arst_n), .i_ahb(i_ahb), .o_ahb(o_ahb),
  .o_pkt_valid(o_pkt_valid), .o_pkt_bits(o_pkt_bits),
  .i_pkt_ready(i_pkt_ready), .o_port_interrupt_out(o_port_interrupt_out),
  .o_tx_pkt_addr(o_tx_pkt_addr), .i_rx_pkt_addr(i_rx_pkt_addr),
  .o_rx_local_addr(o_rx_local_addr), .o_rx_region1_hit(o_rx_region1_hit),
  .o_interrupt_pointer(o_interrupt_pointer));

// [verif/slia_regs_props.sv]
// Port checks of the serial link interrupt and map registers
module slia_regs_props
  import slia_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire slia_ahb_req_s i_ahb,
  input wire slia_ahb_rsp_s o_ahb,
  input wire logic o_pkt_valid,
  input wire logic [31:0] o_pkt_bits,
  input wire logic i_pkt_ready,
  input wire logic o_port_interrupt_out,
  input wire logic [31:0] o_tx_pkt_addr,
  input wire logic [31:0] i_rx_pkt_addr,
  input wire logic [31:0] o_rx_local_addr,
  input wire logic o_rx_region1_hit,
  input wire logic [31:0] o_interrupt_pointer
);
  timeunit 1ns;
  timeprecision 100ps;
  logic take;
  assign take = i_ahb.hsel && i_ahb.hready && i_ahb.htrans[1];
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  a_pkt_holds: assert property (
    o_pkt_valid && !i_pkt_ready |=> o_pkt_valid && $stable(o_pkt_bits))
    else $error("packet changed before acceptance");
  a_pkt_clears: assert property (
    o_pkt_valid && i_pkt_ready |=> !o_pkt_valid)
    else $error("packet still offered after acceptance");
  a_pkt_nonzero: assert property (
    o_pkt_valid |-> o_pkt_bits != 32'h0)
    else $error("empty packet offered");
  a_tx_upper_zero: assert property (
    o_tx_pkt_addr[31:26] == 6'h00)
    else $error("packet address above bit 25");
  a_rx_miss_pass: assert property (
    !o_rx_region1_hit |-> o_rx_local_addr == i_rx_pkt_addr)
    else $error("missed address altered");
  a_ptr_aligned: assert property (
    o_interrupt_pointer[1:0] == 2'h0)
    else $error("pointer low bits set");
  a_hrdata_idle: assert property (
    !$past(take && !i_ahb.hwrite) |-> o_ahb.hrdata == 32'h0)
    else $error("read data outside a read");
  a_local_wr: assert property (
    $rose(o_port_interrupt_out) |-> $past(take && i_ahb.hwrite)
      || $past(take && i_ahb.hwrite, 2) || $past(take && i_ahb.hwrite, 3))
    else $error("local interrupt without a write");
  c_pkt_taken: cover property (o_pkt_valid && i_pkt_ready);
  c_local_int: cover property ($rose(o_port_interrupt_out));
  c_rx_hit: cover property (o_rx_region1_hit);
endmodule : slia_regs_props
